// file: logic/gptrc_timer.v
// General-purpose 16-bit timer with prescaler, compare and capture.
// Assumes a simple register port, bus inputs synchronous to i_core_clk,
// and pin muxing and direction handled outside this block.
//
// How it works
// - Mode bit: restart at match or free-run
// - Capture edge: off, rising, falling, both
// - Output mode: low pulse or toggle
// - Compare output low pulse lasts one clock
// - Interrupt enable gates compare interrupt
// - Clock source: stop, sys, sys/16, pin, slow
// - Stop source holds counter unchanged
// - Enable bit, cleared at reset
// - Prescaler divides by value plus one
// - Compare event when count equals match
// - Match register resets to all ones
// - Capture latches count, holds until next
// - Events set capture and compare flags
// - Flag clears by zero write after read
// - Capture interrupt when enabled and requested
// - Counter readable without disturbing count
`timescale 1ns/10ps
`include "gptrc_regs.vh"

module gptrc_timer #(
  parameter CNT_W = 16,
  parameter PRE_W = 8
) (
  input wire i_core_clk,                      // System clock
  input wire i_rst,                           // Sync reset, active high
  input wire [`GPTRC_ADDR_W-1:0] i_addr,      // Register word address
  input wire [15:0] i_wdata,                  // Write data
  input wire i_wr,                            // Write strobe
  input wire i_rd,                            // Read strobe
  output reg [15:0] o_rdata,                  // Read data, cycle after strobe
  input wire i_timer_input_pin,               // Timer input pin level
  input wire i_low_rate_clock,                // Slow clock level
  output reg o_timer_output_pin,              // Timer output level
  output reg o_irq                            // Timer interrupt level
);

  reg [15:0] ctrl_q;
  reg [PRE_W-1:0] presc_q;
  reg [CNT_W-1:0] match_q;
  reg [CNT_W-1:0] snap_q;
  reg [CNT_W-1:0] count_q;
  reg [PRE_W-1:0] pre_cnt_q;
  reg [3:0] div16_q;
  reg cap_flag_q;
  reg comp_flag_q;
  reg cap_seen_q;
  reg comp_seen_q;
  wire pin_rise;
  wire pin_fall;
  wire slow_rise;

  wire free_run = ctrl_q[`GPTRC_CTRL_FREE];
  wire [1:0] cap_sel = ctrl_q[`GPTRC_CTRL_CAP_HI:`GPTRC_CTRL_CAP_LO];
  wire out_toggle = ctrl_q[`GPTRC_CTRL_TOGGLE];
  wire irq_en = ctrl_q[`GPTRC_CTRL_IRQ_ENA];
  wire [2:0] src_sel = ctrl_q[`GPTRC_CTRL_SRC_HI:`GPTRC_CTRL_SRC_LO];
  wire timer_on = ctrl_q[`GPTRC_CTRL_ENABLE];

  wire div16_wrap = (div16_q == `GPTRC_SYS16_LAST);

  wire wr_ctrl = i_wr && (i_addr == `GPTRC_OFS_CTRL);
  wire wr_presc = i_wr && (i_addr == `GPTRC_OFS_PRESC);
  wire wr_match = i_wr && (i_addr == `GPTRC_OFS_MATCH);
  wire wr_stat = i_wr && (i_addr == `GPTRC_OFS_STAT);
  wire rd_stat = i_rd && (i_addr == `GPTRC_OFS_STAT);

  reg src_edge;
  reg tick;
  reg comp_ev;
  reg cap_ev;
  reg [15:0] rd_mux;

  // Source edge selection
  always @* begin
    src_edge = 1'b0;
    case (src_sel)
      `GPTRC_SRC_STOP: src_edge = 1'b0;
      `GPTRC_SRC_SYS: src_edge = 1'b1;
      `GPTRC_SRC_SYS16: src_edge = div16_wrap;
      `GPTRC_SRC_PIN: src_edge = pin_rise;
      // Pin source counts rising edges; falling edges only capture
      default: src_edge = slow_rise;
    endcase
  end

  // Count tick, compare and capture events
  always @* begin
    // Compare only on a tick: the count sits on the match value a whole tick
    tick = timer_on && src_edge && (pre_cnt_q == presc_q);
    comp_ev = tick && (count_q == match_q);
    cap_ev = 1'b0;
    case (cap_sel)
      `GPTRC_CAP_RISE: cap_ev = timer_on && pin_rise;
      `GPTRC_CAP_FALL: cap_ev = timer_on && pin_fall;
      `GPTRC_CAP_BOTH: cap_ev = timer_on && (pin_rise || pin_fall);
      default: cap_ev = 1'b0;
    endcase
  end

  // Capture and pin clock edges, synchronised before use
  gptrc_sync_edge u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_level(i_timer_input_pin),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // Slow clock counts on rising edges only
  gptrc_sync_edge u_slow_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_level(i_low_rate_clock),
    .o_rise(slow_rise),
    .o_fall()
  );

  // Free-running divide by 16 of the system clock
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      div16_q <= 4'h0;
    end else begin
      div16_q <= div16_q + 4'h1;
    end
  end

  // Control, prescaler and match registers
  // Snapshot, count and unmapped addresses ignore writes
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_q <= `GPTRC_RST_CTRL;
      presc_q <= `GPTRC_RST_PRESC;
      match_q <= `GPTRC_RST_MATCH;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_wdata & `GPTRC_CTRL_MASK;
      end
      if (wr_presc) begin
        presc_q <= i_wdata[PRE_W-1:0];
      end
      if (wr_match) begin
        match_q <= i_wdata[CNT_W-1:0];
      end
    end
  end

  // Prescaler: one tick per presc_q+1 source edges
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      pre_cnt_q <= {PRE_W{1'b0}};
    end else if (wr_presc) begin
      // A new ratio restarts the divider, so a smaller one never waits for a wrap
      pre_cnt_q <= {PRE_W{1'b0}};
    end else if (timer_on && src_edge) begin
      if (pre_cnt_q == presc_q) begin
        pre_cnt_q <= {PRE_W{1'b0}};
      end else begin
        pre_cnt_q <= pre_cnt_q + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Counter; holds when disabled or stopped
  // Restart beats the tick, so the count after a match is zero
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      count_q <= {CNT_W{1'b0}};
    end else if (comp_ev && !free_run) begin
      count_q <= {CNT_W{1'b0}};
    end else if (tick) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Capture snapshot
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      snap_q <= {CNT_W{1'b0}};
    end else if (cap_ev) begin
      snap_q <= count_q;
    end
  end

  // Status flags; a new event beats a clear in the same cycle
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      cap_flag_q <= 1'b0;
      comp_flag_q <= 1'b0;
      cap_seen_q <= 1'b0;
      comp_seen_q <= 1'b0;
    end else begin
      if (cap_ev) begin
        cap_flag_q <= 1'b1;
      end else if (wr_stat && !i_wdata[`GPTRC_STAT_CAPTURE] && cap_seen_q) begin
        cap_flag_q <= 1'b0;
      end
      if (comp_ev) begin
        comp_flag_q <= 1'b1;
      end else if (wr_stat && !i_wdata[`GPTRC_STAT_COMP] && comp_seen_q) begin
        comp_flag_q <= 1'b0;
      end
      // Read arms the clear only for bits seen as one
      // A status write without a status read in the same cycle disarms both, so a stale read cannot clear later
      if (rd_stat) begin
        cap_seen_q <= cap_flag_q;
        comp_seen_q <= comp_flag_q;
      end else if (wr_stat) begin
        cap_seen_q <= 1'b0;
        comp_seen_q <= 1'b0;
      end
    end
  end

  // Output pin: low for one clock, or a toggle, per compare event
  // Idles high because the pulse is active low
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_timer_output_pin <= 1'b1;
    end else if (comp_ev) begin
      o_timer_output_pin <= out_toggle ? ~o_timer_output_pin : 1'b0;
    end else if (!out_toggle) begin
      o_timer_output_pin <= 1'b1;
    end
  end

  // Interrupt follows held flags so it stays until cleared
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_en && (comp_flag_q || (cap_flag_q && (cap_sel != `GPTRC_CAP_OFF)));
    end
  end

  // Read mux; unused bits and unmapped addresses read zero
  always @* begin
    rd_mux = 16'h0000;
    case (i_addr)
      `GPTRC_OFS_CTRL: rd_mux = ctrl_q;
      `GPTRC_OFS_PRESC: rd_mux[PRE_W-1:0] = presc_q;
      `GPTRC_OFS_MATCH: rd_mux[CNT_W-1:0] = match_q;
      `GPTRC_OFS_SNAP: rd_mux[CNT_W-1:0] = snap_q;
      `GPTRC_OFS_COUNT: rd_mux[CNT_W-1:0] = count_q;
      `GPTRC_OFS_STAT: rd_mux = {14'h0000, cap_flag_q, comp_flag_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data stands one cycle and is zero otherwise
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

// Two-flop synchroniser plus one history flop, giving one-cycle edge strobes.
// Only the second and third stages are read outside the chain, so metastability stays in stage one.
module gptrc_sync_edge (
  input wire i_core_clk, // System clock
  input wire i_rst, // Sync reset, active high
  input wire i_level, // Level from outside the clock domain
  output wire o_rise, // Rising edge, one cycle
  output wire o_fall // Falling edge, one cycle
);

  reg meta_q;
  reg sync_q;
  reg hist_q;

  // Resets low; a pin idling high shows one rise after reset
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      hist_q <= 1'b0;
    end else begin
      meta_q <= i_level;
      sync_q <= meta_q;
      hist_q <= sync_q;
    end
  end

  assign o_rise = sync_q & ~hist_q;
  assign o_fall = ~sync_q & hist_q;

endmodule

// file: shared/gptrc_regs.vh
// Register map, field positions and reset values of the timer.
// Assumes a word-addressed register port of three address bits.
`ifndef GPTRC_REGS_VH
`define GPTRC_REGS_VH

`define GPTRC_ADDR_W 3
`define GPTRC_OFS_CTRL 3'h0
`define GPTRC_OFS_PRESC 3'h1
`define GPTRC_OFS_MATCH 3'h2
`define GPTRC_OFS_SNAP 3'h3
`define GPTRC_OFS_COUNT 3'h4
`define GPTRC_OFS_STAT 3'h5

`define GPTRC_CTRL_FREE 8
`define GPTRC_CTRL_CAP_HI 7
`define GPTRC_CTRL_CAP_LO 6
`define GPTRC_CTRL_TOGGLE 5
`define GPTRC_CTRL_IRQ_ENA 4
`define GPTRC_CTRL_SRC_HI 3
`define GPTRC_CTRL_SRC_LO 1
`define GPTRC_CTRL_ENABLE 0
`define GPTRC_CTRL_MASK 16'h01ff

`define GPTRC_STAT_CAPTURE 1
`define GPTRC_STAT_COMP 0

`define GPTRC_CAP_OFF 2'h0
`define GPTRC_CAP_RISE 2'h1
`define GPTRC_CAP_FALL 2'h2
`define GPTRC_CAP_BOTH 2'h3

`define GPTRC_SRC_STOP 3'h0
`define GPTRC_SRC_SYS 3'h1
`define GPTRC_SRC_SYS16 3'h2
`define GPTRC_SRC_PIN 3'h3

`define GPTRC_RST_CTRL 16'h0000
`define GPTRC_RST_PRESC 8'h00
`define GPTRC_RST_MATCH 16'hffff
`define GPTRC_SYS16_LAST 4'hf

`endif

// file: tb/gptrc_pin_src.sv
// Far-side source on the timer input pin.
// Assumes the pin is handed to the timer as an input.
`timescale 1ns/10ps
module gptrc_pin_src (
  input wire i_core_clk, // Clock
  input wire [7:0] i_half, // Cycles per level, 0 follows i_lvl
  input wire i_lvl, // Held level
  output reg o_pin // Pin level
);
  reg [7:0] cnt_q;
  initial begin
    o_pin = 1'b0;
    cnt_q = 8'h00;
  end
  always @(posedge i_core_clk) begin
    cnt_q <= (cnt_q + 8'h01 >= i_half) ? 8'h00 : cnt_q + 8'h01;
    if (i_half == 8'h00) o_pin <= i_lvl;
    else if (cnt_q + 8'h01 >= i_half) o_pin <= ~o_pin;
  end
endmodule

// file: tb/gptrc_timer_asserts.sv
// Port checker for the timer.
// Assumes one clock and the register map header.
`timescale 1ns/10ps
`include "gptrc_regs.vh"
module gptrc_timer_asserts (
  input wire i_core_clk, // Clock
  input wire i_rst, // Reset
  input wire [`GPTRC_ADDR_W-1:0] i_addr, // Address
  input wire [15:0] i_wdata, // Write data
  input wire i_wr, // Write
  input wire i_rd, // Read
  input wire [15:0] o_rdata, // Read data
  input wire o_timer_output_pin, // Output
  input wire o_irq // Interrupt
);
  reg [15:0] ctrl_q, match_q;
  // Shadows, since only the bus is visible here
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_q <= 16'h0000;
      match_q <= 16'hffff;
    end else if (i_wr) begin
      if (i_addr == `GPTRC_OFS_CTRL) ctrl_q <= i_wdata & `GPTRC_CTRL_MASK;
      if (i_addr == `GPTRC_OFS_MATCH) match_q <= i_wdata;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_low;
    $fell(o_timer_output_pin) && !ctrl_q[`GPTRC_CTRL_TOGGLE];
  endsequence
  AST_PULSE_ONE: assert property (s_low |=> o_timer_output_pin)
    else $error("pulse width");
  AST_IRQ_GATED: assert property (o_irq |-> $past(ctrl_q[`GPTRC_CTRL_IRQ_ENA]))
    else $error("irq gate");
  AST_HOLD_OFF: assert property ((!ctrl_q[`GPTRC_CTRL_ENABLE]) [*3] |=> $stable(o_timer_output_pin))
    else $error("disabled output");
  AST_STOP_HOLD: assert property ((ctrl_q[3:1] == 3'h0) [*3] |=> $stable(o_timer_output_pin))
    else $error("stopped output");
  AST_CTRL_READ: assert property (i_rd && i_addr == `GPTRC_OFS_CTRL |=> o_rdata == ctrl_q)
    else $error("ctrl read");
  AST_MATCH_READ: assert property (i_rd && i_addr == `GPTRC_OFS_MATCH |=> o_rdata == match_q)
    else $error("match read");
  AST_PRESC_HI: assert property (i_rd && i_addr == `GPTRC_OFS_PRESC |=> o_rdata[15:8] == 8'h00)
    else $error("presc upper");
  AST_STAT_HI: assert property (i_rd && i_addr == `GPTRC_OFS_STAT |=> o_rdata[15:2] == 14'h0000)
    else $error("status upper");
endmodule
bind gptrc_timer gptrc_timer_asserts chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_timer_output_pin(o_timer_output_pin),
  .o_irq(o_irq));

// file: tb/gptrc_timer_bench.sv
// Bench: bus tasks, period model and capture checks.
// Assumes the checker binds itself to the timer.
`timescale 1ns/10ps
module gptrc_timer_bench;
  reg clk, rst, wr, rd, slow, lvl;
  reg [2:0] addr;
  reg [15:0] wd, rv, c0;
  reg [7:0] half;
  wire [15:0] rdata;
  wire pin, out_pin, irq;
  integer miscompares, total_checks, cyc, seed, i, j, t0, t1, m, p, tog, ie;
  integer sv[0:3], dv[0:3];
  gptrc_timer dut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_timer_input_pin(pin), .i_low_rate_clock(slow), .o_timer_output_pin(out_pin), .o_irq(irq));
  gptrc_pin_src far (.i_core_clk(clk), .i_half(half), .i_lvl(lvl), .o_pin(pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 7 == 6) slow <= ~slow;
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  endtask
  task wreg(input [2:0] a, input [15:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input [2:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  // Pulse mode counts falls only, toggle mode every change
  task wevt(output integer t);
    reg pv;
    integer n;
    n = 0;
    @(negedge clk);
    pv = out_pin;
    @(negedge clk);
    while (!(out_pin !== pv && (tog != 0 || out_pin === 1'b0)) && n < 3000) begin
      pv = out_pin; n = n + 1;
      @(negedge clk);
    end
    if (n >= 3000) miscompares = miscompares + 1;
    t = cyc;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares = miscompares + 1;
    finish_test;
  end
  initial begin
    seed = 3; miscompares = 0; total_checks = 0; cyc = 0; rst = 1'b1; wr = 1'b0; rd = 1'b0;
    addr = 3'h0; wd = 16'h0000; slow = 1'b0; lvl = 1'b0; half = 8'h00;
    sv[0] = 1; sv[1] = 2; sv[2] = 3; sv[3] = 5;
    dv[0] = 1; dv[1] = 16; dv[2] = 10; dv[3] = 14;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i = i + 1) begin
      rreg(i[2:0]);
      chk("reset", (i == 2) ? 16'hffff : 16'h0000, rv);
    end
    c0 = $random(seed);
    wreg(0, c0 & 16'h01fe); rreg(0); chk("ctrl", c0 & 16'h01fe, rv);
    wreg(1, c0); rreg(1); chk("presc", c0 & 16'h00ff, rv);
    half = 8'h05;
    for (i = 0; i < 8; i = i + 1) begin
      m = 1 + i / 3; p = {$random(seed)} % 3; ie = {$random(seed)} % 2; tog = (i >= 4);
      wreg(0, 16'h0000); wreg(1, p); wreg(2, m);
      rreg(5); wreg(5, 0); rreg(5); chk("compare clear", 16'h0000, rv & 16'h0001);
      wreg(0, tog * 32 + ie * 16 + sv[i % 4] * 2 + 1);
      wevt(t0); wevt(t1);
      chk("period", dv[i % 4] * (m + 1) * (p + 1), t1 - t0);
      chk("irq", ie, irq);
      rreg(5); chk("compare flag", 16'h0001, rv & 16'h0001);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wreg(0, 16'h0000); wreg(1, 0); wreg(2, 3); wreg(0, i * 256 + 16'h0023);
      wevt(t0); rreg(4);
      chk("free run", i, rv > 3);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wreg(0, i ? 16'h0101 : 16'h0102); rreg(4); c0 = rv;
      repeat (20) @(posedge clk);
      rreg(4); chk("hold", c0, rv);
    end
    half = 8'h00;
    for (i = 0; i < 4; i = i + 1) begin
      wreg(0, i * 64 + 16'h0113);
      for (j = 0; j < 2; j = j + 1) begin
        rreg(5); wreg(5, 0); rreg(4); c0 = rv;
        @(posedge clk);
        lvl <= (j == 0);
        repeat (8) @(posedge clk);
        rreg(5); chk("capture", ((i >> j) & 1) * 2, rv & 16'h0002);
        chk("capture irq", (i >> j) & 1, irq);
        rreg(3);
        if ((i >> j) & 1) chk("snapshot", 1, (rv - c0) < 16'h0010);
      end
    end
    finish_test;
  end
endmodule
